// >>> verilog/dgt_timer_unit.sv
// Dual group timer unit with Avalon-MM register slave
`default_nettype none
// Summary of operation
// - Five 16-bit timers in two groups
// - Group one modes: timer, gated, counter, incremental
// - Timer mode counts prescaled system clock
// - Counter mode counts input pin edges
// - Gated mode counts while gate level active
// - Group one ticks every four clocks minimum
// - Direction by software or direction pin
// - Incremental mode tracks quadrature A/B position
// - Core latch toggles on wrap, drives pin
// - Capture or reload auxiliary timer stops counting
// - Capture copies core value on input edge
// - Reload loads core on input or latch
// - Two reload auxiliaries alternate for PWM
// - Some auxiliary inputs have no pins
// - Group two ticks every two clocks minimum
// - Group two prescaled or external, direction selectable
// - Second core latch toggles, clocks aux, pin
// - Second core wrap clocks array, reloads
// - Capture pin latches second aux, optional clear
// - Core input or direction edges also capture
module dgt_timer_unit
  import dgt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic core_timer_input,
  input wire logic core_timer_direction_input,
  input wire logic aux_b_input,
  input wire logic g2_aux_input,
  input wire logic g2_aux_direction,
  input wire logic g2_core_input,
  input wire logic capture_trigger_pin,
  output logic core_toggle_output_pin,
  output logic second_core_toggle_output_pin,
  output logic compare_array_clock,
  output logic [4:0] wrap_event,
  output logic [4:0] wrap_flags
);

  dgt_state_s q;
  dgt_state_s d;

  logic req;
  logic bus_we;
  logic [4:0] in_lvl;
  logic [4:0] in_rise;
  logic [4:0] in_fall;
  logic [4:0] dir_lvl;
  logic [4:0] dir_edge;
  logic [4:0] tick_v;
  logic [4:0] en_v;
  logic [4:0] down_v;
  logic [4:0] wrap_v;
  logic [4:0][15:0] nxt_v;
  logic [4:0] rel_v;
  logic [4:0] cap_v;
  logic l1_rise;
  logic l1_fall;
  logic l2_rise;
  logic l2_fall;
  logic cap2_v;
  logic [16:0] stp;

  function automatic logic [16:0] step16(input logic [15:0] v,
                                         input logic en,
                                         input logic down);
    logic [15:0] nv;
    logic w;
    nv = v;
    w = 1'b0;
    if (en) begin
      if (down) begin
        nv = v - 16'h0001;
        w = (v == 16'h0000);
      end else begin
        nv = v + 16'h0001;
        w = (v == 16'hFFFF);
      end
    end
    return {w, nv};
  endfunction : step16

  function automatic logic prescale_hit(input logic [15:0] pc,
                                        input logic [2:0] pre,
                                        input logic grp2);
    logic [15:0] base;
    base = grp2 ? DGT_G2_DIV : DGT_G1_DIV;
    return (pc & ((base << pre) - 16'h0001)) == 16'h0000;
  endfunction : prescale_hit

  function automatic logic edge_sel(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction : edge_sel

  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  // Waitrequest is released one cycle after the request is seen
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~q.ack;
  assign avs_readdata = q.rdata;
  assign core_toggle_output_pin = q.latch1;
  assign second_core_toggle_output_pin = q.latch2;
  assign compare_array_clock = q.cmp_clk;
  assign wrap_event = q.wrap_ev;
  assign wrap_flags = q.flags;

  always_comb begin
    d = q;
    bus_we = req & q.ack & avs_write;
    // Only the second stage and later feed any logic
    d.s1 = {capture_trigger_pin, g2_core_input, g2_aux_direction,
            g2_aux_input, aux_b_input, core_timer_direction_input,
            core_timer_input};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pre_cnt = q.pre_cnt + 16'h0001;
    // Aux A input and direction, aux B and second core direction unwired
    in_lvl = {q.s2[DGT_P_G2CORE_IN], q.s2[DGT_P_G2AUX_IN],
              q.s2[DGT_P_AUXB_IN], q.s2[DGT_P_CORE_IN], 1'b0};
    in_rise = in_lvl & ~{q.s3[DGT_P_G2CORE_IN], q.s3[DGT_P_G2AUX_IN],
                         q.s3[DGT_P_AUXB_IN], q.s3[DGT_P_CORE_IN],
                         1'b0};
    in_fall = ~in_lvl & {q.s3[DGT_P_G2CORE_IN], q.s3[DGT_P_G2AUX_IN],
                         q.s3[DGT_P_AUXB_IN], q.s3[DGT_P_CORE_IN], 1'b0};
    dir_lvl = {1'b0, q.s2[DGT_P_G2AUX_DIR], 1'b0,
               q.s2[DGT_P_CORE_DIR], 1'b0};
    dir_edge = dir_lvl ^ {1'b0, q.s3[DGT_P_G2AUX_DIR], 1'b0,
                          q.s3[DGT_P_CORE_DIR], 1'b0};
    tick_v = '0;
    en_v = '0;
    down_v = '0;
    rel_v = '0;
    cap_v = '0;
    stp = '0;
    for (int i = 0; i < DGT_NUM_TIMERS; i++) begin
      tick_v[i] = prescale_hit(q.pre_cnt, q.ctl[i][DGT_CF_PRE +: 3],
                               i >= DGT_G2_AUX);
      down_v[i] = q.ctl[i][DGT_CF_DOWN] ^
                  (q.ctl[i][DGT_CF_DIREXT] & dir_lvl[i]);
      case (dgt_mode_e'(q.ctl[i][DGT_CF_MODE +: 2]))
        DGT_TIMER: begin
          en_v[i] = tick_v[i];
        end
        DGT_GATED: begin
          en_v[i] = tick_v[i] &
                    (in_lvl[i] == q.ctl[i][DGT_CF_GATE_HI]);
        end
        DGT_COUNTER: begin
          en_v[i] = edge_sel(q.ctl[i][DGT_CF_EDGE +: 2], in_rise[i],
                             in_fall[i]);
        end
        DGT_INCR: begin
          // Simultaneous A and B edges are an illegal sensor step
          if (i < DGT_G2_AUX) begin
            en_v[i] = (in_rise[i] | in_fall[i]) ^ dir_edge[i];
            down_v[i] = (in_rise[i] | in_fall[i]) ?
                        (in_lvl[i] == dir_lvl[i]) :
                        (in_lvl[i] != dir_lvl[i]);
          end
        end
        default: begin
          en_v[i] = 1'b0;
        end
      endcase
      en_v[i] = en_v[i] & q.ctl[i][DGT_CF_RUN];
    end
    // Latch edges are known in the wrap cycle so reloads lose no count
    stp = step16(q.cnt[DGT_CORE], en_v[DGT_CORE], down_v[DGT_CORE]);
    l1_rise = stp[16] & ~q.latch1;
    l1_fall = stp[16] & q.latch1;
    stp = step16(q.cnt[DGT_G2_CORE], en_v[DGT_G2_CORE],
                 down_v[DGT_G2_CORE]);
    l2_rise = stp[16] & ~q.latch2;
    l2_fall = stp[16] & q.latch2;
    for (int i = 0; i < DGT_NUM_TIMERS; i++) begin
      if (q.ctl[i][DGT_CF_LSRC] &&
          q.ctl[i][DGT_CF_MODE +: 2] == 2'(DGT_COUNTER)) begin
        if (i == DGT_AUX_A || i == DGT_AUX_B) begin
          en_v[i] = q.ctl[i][DGT_CF_RUN] &
                    edge_sel(q.ctl[i][DGT_CF_EDGE +: 2], l1_rise,
                             l1_fall);
        end else if (i == DGT_G2_AUX) begin
          en_v[i] = q.ctl[i][DGT_CF_RUN] &
                    edge_sel(q.ctl[i][DGT_CF_EDGE +: 2], l2_rise,
                             l2_fall);
        end
      end
      if ((i == DGT_AUX_A || i == DGT_AUX_B) &&
          q.ctl[i][DGT_CF_FUNC +: 2] != DGT_FUNC_NORMAL) begin
        en_v[i] = 1'b0;
        if (q.ctl[i][DGT_CF_FUNC +: 2] == DGT_FUNC_CAPTURE) begin
          cap_v[i] = edge_sel(q.ctl[i][DGT_CF_EDGE +: 2], in_rise[i],
                              in_fall[i]);
        end else if (q.ctl[i][DGT_CF_FUNC +: 2] == DGT_FUNC_RELOAD) begin
          case (q.ctl[i][DGT_CF_RTRIG +: 2])
            DGT_RT_INPUT: begin
              rel_v[i] = edge_sel(q.ctl[i][DGT_CF_EDGE +: 2], in_rise[i],
                                  in_fall[i]);
            end
            DGT_RT_LATCH_RISE: begin
              rel_v[i] = l1_rise;
            end
            DGT_RT_LATCH_FALL: begin
              rel_v[i] = l1_fall;
            end
            default: begin
              rel_v[i] = l1_rise | l1_fall;
            end
          endcase
        end
      end
    end
    for (int i = 0; i < DGT_NUM_TIMERS; i++) begin
      {wrap_v[i], nxt_v[i]} = step16(q.cnt[i], en_v[i], down_v[i]);
      d.cnt[i] = nxt_v[i];
    end
    d.latch1 = q.latch1 ^ wrap_v[DGT_CORE];
    d.latch2 = q.latch2 ^ wrap_v[DGT_G2_CORE];
    d.cmp_clk = wrap_v[DGT_G2_CORE];
    d.wrap_ev = wrap_v;
    // Aux B reload wins if both auxiliaries fire together
    for (int i = 0; i <= DGT_AUX_B; i += 2) begin
      if (cap_v[i]) begin
        d.cnt[i] = q.cnt[DGT_CORE];
      end
      if (rel_v[i]) begin
        d.cnt[DGT_CORE] = q.cnt[i];
      end
    end
    if (q.capctl[DGT_CC_RELOAD] && wrap_v[DGT_G2_CORE]) begin
      d.cnt[DGT_G2_CORE] = q.cap_reg;
    end
    cap2_v = (q.capctl[DGT_CC_PIN_EN] &
              edge_sel(q.capctl[DGT_CC_EDGE +: 2],
                       q.s2[DGT_P_CAP] & ~q.s3[DGT_P_CAP],
                       ~q.s2[DGT_P_CAP] & q.s3[DGT_P_CAP])) |
             (q.capctl[DGT_CC_CIN_EN] &
              (in_rise[DGT_CORE] | in_fall[DGT_CORE])) |
             (q.capctl[DGT_CC_CDIR_EN] & dir_edge[DGT_CORE]);
    if (cap2_v) begin
      d.cap_reg = q.cnt[DGT_G2_AUX];
      if (q.capctl[DGT_CC_CLEAR]) begin
        d.cnt[DGT_G2_AUX] = DGT_CNT_RST;
      end
    end
    // Bus access: read data staged in the first cycle, write in the second
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      d.rdata = '0;
      for (int i = 0; i < DGT_NUM_TIMERS; i++) begin
        if (avs_address == DGT_CTL_BASE + 7'(i * 4)) begin
          d.rdata = {16'h0000, q.ctl[i]};
        end
        if (avs_address == DGT_CNT_BASE + 7'(i * 4)) begin
          d.rdata = {16'h0000, q.cnt[i]};
        end
      end
      if (avs_address == DGT_CAP_REG) begin
        d.rdata = {16'h0000, q.cap_reg};
      end
      if (avs_address == DGT_CAPCTL) begin
        d.rdata = {24'h000000, q.capctl};
      end
      if (avs_address == DGT_STATUS) begin
        d.rdata = {27'h0000000, q.flags};
      end
    end
    d.flags = q.flags;
    if (bus_we) begin
      // Software counter writes override hardware updates
      for (int i = 0; i < DGT_NUM_TIMERS; i++) begin
        if (avs_address == DGT_CTL_BASE + 7'(i * 4)) begin
          d.ctl[i] = be_merge(q.ctl[i], avs_writedata, avs_byteenable);
        end
        if (avs_address == DGT_CNT_BASE + 7'(i * 4)) begin
          d.cnt[i] = be_merge(q.cnt[i], avs_writedata, avs_byteenable);
        end
      end
      if (avs_address == DGT_CAP_REG) begin
        d.cap_reg = be_merge(q.cap_reg, avs_writedata, avs_byteenable);
      end
      if (avs_address == DGT_CAPCTL && avs_byteenable[0]) begin
        d.capctl = avs_writedata[7:0];
      end
      if (avs_address == DGT_STATUS && avs_byteenable[0]) begin
        d.flags = q.flags & ~avs_writedata[4:0];
      end
    end
    // A wrap in the clearing cycle is kept
    d.flags = d.flags | wrap_v;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.ctl <= {DGT_NUM_TIMERS{DGT_CTL_RST}};
      q.cnt <= {DGT_NUM_TIMERS{DGT_CNT_RST}};
      q.capctl <= DGT_CAPCTL_RST;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  g1_tick_grid_a:
    assert property (tick_v[DGT_CORE] |-> q.pre_cnt[1:0] == 2'h0)
    else $error("group one tick off its four-cycle grid");

  g2_tick_grid_a:
    assert property (tick_v[DGT_G2_CORE] |-> q.pre_cnt[0] == 1'b0)
    else $error("group two tick off its two-cycle grid");

  core_latch_toggle_a:
    assert property (wrap_v[DGT_CORE] |=>
                     core_toggle_output_pin != $past(q.latch1))
    else $error("core latch did not toggle on wrap");

  aux_stopped_a:
    assert property (q.ctl[DGT_AUX_B][DGT_CF_FUNC +: 2] != DGT_FUNC_NORMAL
                     && !cap_v[DGT_AUX_B] && !bus_we |=>
                     $stable(q.cnt[DGT_AUX_B]))
    else $error("aux timer counted while capture or reload");

  capture_copy_a:
    assert property (cap_v[DGT_AUX_B] && !bus_we |=>
                     q.cnt[DGT_AUX_B] == $past(q.cnt[DGT_CORE]))
    else $error("aux capture did not copy core value");

  core_reload_a:
    assert property (rel_v[DGT_AUX_B] && !bus_we |=>
                     q.cnt[DGT_CORE] == $past(q.cnt[DGT_AUX_B]))
    else $error("core not reloaded from aux");

  g2_wrap_out_a:
    assert property (wrap_v[DGT_G2_CORE] |=> compare_array_clock &&
                     second_core_toggle_output_pin != $past(q.latch2)
                     ##1 compare_array_clock == $past(wrap_v[DGT_G2_CORE]))
    else $error("second core wrap not reported");

  cap_reg_latch_a:
    assert property (cap2_v && !bus_we |=>
                     q.cap_reg == $past(q.cnt[DGT_G2_AUX]))
    else $error("capture register missed second aux value");

  core_wrap_zero_a:
    assert property (wrap_v[DGT_CORE] && !down_v[DGT_CORE] && !bus_we &&
                     rel_v == 5'h00 |=> q.cnt[DGT_CORE] == 16'h0000 &&
                     wrap_flags[DGT_CORE])
    else $error("core up wrap not to zero or unflagged");

  bus_answer_a:
    assert property (req && !q.ack |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");

  reload_seen_c: cover property (rel_v[DGT_AUX_B]);
  capture_seen_c: cover property (cap_v[DGT_AUX_B]);
  cap_reg_seen_c: cover property (cap2_v);
  core_wrap_c: cover property (wrap_v[DGT_CORE]);

endmodule : dgt_timer_unit
`default_nettype wire

// >>> verilog/dgt_pkg.sv
// Constants, register map and types for the dual group timer unit
`default_nettype none
package dgt_pkg;
  // Timer slots in the counter and control arrays
  localparam int DGT_NUM_TIMERS = 5;
  localparam int DGT_AUX_A = 0;
  localparam int DGT_CORE = 1;
  localparam int DGT_AUX_B = 2;
  localparam int DGT_G2_AUX = 3;
  localparam int DGT_G2_CORE = 4;

  // Synchronised pin slots
  localparam int DGT_NUM_PINS = 7;
  localparam int DGT_P_CORE_IN = 0;
  localparam int DGT_P_CORE_DIR = 1;
  localparam int DGT_P_AUXB_IN = 2;
  localparam int DGT_P_G2AUX_IN = 3;
  localparam int DGT_P_G2AUX_DIR = 4;
  localparam int DGT_P_G2CORE_IN = 5;
  localparam int DGT_P_CAP = 6;

  // Byte offsets on the register bus
  localparam int DGT_ADDR_W = 7;
  localparam logic [6:0] DGT_CTL_BASE = 7'h00;
  localparam logic [6:0] DGT_CNT_BASE = 7'h20;
  localparam logic [6:0] DGT_CAP_REG = 7'h40;
  localparam logic [6:0] DGT_CAPCTL = 7'h44;
  localparam logic [6:0] DGT_STATUS = 7'h48;

  // Timer control word fields
  localparam int DGT_CF_MODE = 0;
  localparam int DGT_CF_PRE = 2;
  localparam int DGT_CF_RUN = 5;
  localparam int DGT_CF_DOWN = 6;
  localparam int DGT_CF_DIREXT = 7;
  localparam int DGT_CF_EDGE = 8;
  localparam int DGT_CF_GATE_HI = 10;
  localparam int DGT_CF_FUNC = 11;
  localparam int DGT_CF_RTRIG = 13;
  localparam int DGT_CF_LSRC = 15;

  // Auxiliary function codes
  localparam logic [1:0] DGT_FUNC_NORMAL = 2'h0;
  localparam logic [1:0] DGT_FUNC_RELOAD = 2'h1;
  localparam logic [1:0] DGT_FUNC_CAPTURE = 2'h2;

  // Reload trigger codes
  localparam logic [1:0] DGT_RT_INPUT = 2'h0;
  localparam logic [1:0] DGT_RT_LATCH_RISE = 2'h1;
  localparam logic [1:0] DGT_RT_LATCH_FALL = 2'h2;

  // Capture/reload control fields
  localparam int DGT_CC_PIN_EN = 0;
  localparam int DGT_CC_CIN_EN = 1;
  localparam int DGT_CC_CDIR_EN = 2;
  localparam int DGT_CC_CLEAR = 3;
  localparam int DGT_CC_RELOAD = 4;
  localparam int DGT_CC_EDGE = 5;

  // Base prescaler divisors in system clock cycles
  localparam logic [15:0] DGT_G1_DIV = 16'h0004;
  localparam logic [15:0] DGT_G2_DIV = 16'h0002;

  // Reset values
  localparam logic [15:0] DGT_CTL_RST = 16'h0000;
  localparam logic [15:0] DGT_CNT_RST = 16'h0000;
  localparam logic [7:0] DGT_CAPCTL_RST = 8'h00;

  typedef enum logic [1:0] {
    DGT_TIMER,
    DGT_GATED,
    DGT_COUNTER,
    DGT_INCR
  } dgt_mode_e;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [15:0] pre_cnt;
    logic [4:0][15:0] cnt;
    logic [4:0][15:0] ctl;
    logic [15:0] cap_reg;
    logic [7:0] capctl;
    logic latch1;
    logic latch2;
    logic [4:0] flags;
    logic [4:0] wrap_ev;
    logic cmp_clk;
    logic ack;
    logic [31:0] rdata;
  } dgt_state_s;
endpackage : dgt_pkg
`default_nettype wire

// >>> tb/dgt_quad_sensor.sv
// Quadrature position sensor model for the core timer pins
`default_nettype none
module dgt_quad_sensor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic rev,
  output logic sig_a,
  output logic sig_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  logic [1:0] div;
  // Gray order 00,10,11,01: one line moves per step
  assign sig_a = phase[1] ^ phase[0];
  assign sig_b = phase[1];
  // One step per four clocks keeps each level well above one clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
      div <= 2'h0;
    end else if (!go) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        phase <= rev ? phase - 2'h1 : phase + 2'h1;
      end
    end
  end
endmodule : dgt_quad_sensor
`default_nettype wire

// >>> tb/dual_group_timer_unit_bench.sv
// Self-checking bench for the dual group timer unit
`default_nettype none
module dual_group_timer_unit_bench import dgt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic pin_in, pin_dir, aux_b_in, g2_aux_in, g2_aux_dir, g2_core_in;
  logic cap_pin, quad_sel, quad_go, quad_rev, quad_a, quad_b;
  logic core_a, core_b, core_out, core2_out, cmp_clk;
  logic [4:0] wrap_ev, wrap_fl;
  int n_mismatch = 0;
  int comparisons = 0;
  int ev_n = 0;
  int cmp_n = 0;
  assign core_a = quad_sel ? quad_a : pin_in;
  assign core_b = quad_sel ? quad_b : pin_dir;
  dgt_timer_unit i_dgt_timer_unit (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_timer_input(core_a),
    .core_timer_direction_input(core_b), .aux_b_input(aux_b_in),
    .g2_aux_input(g2_aux_in), .g2_aux_direction(g2_aux_dir),
    .g2_core_input(g2_core_in), .capture_trigger_pin(cap_pin),
    .core_toggle_output_pin(core_out),
    .second_core_toggle_output_pin(core2_out),
    .compare_array_clock(cmp_clk), .wrap_event(wrap_ev),
    .wrap_flags(wrap_fl));
  dgt_quad_sensor i_dgt_quad_sensor (.clk(clk), .reset_n(reset_n),
    .go(quad_go), .rev(quad_rev), .sig_a(quad_a), .sig_b(quad_b));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Registered outputs read here see the value from before the edge
  always @(posedge clk) begin
    ev_n <= ev_n + int'(wrap_ev[DGT_CORE]);
    cmp_n <= cmp_n + int'(cmp_clk);
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [6:0] a,
      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check("bus answer", {15'h0000, n < 50}, 16'h0001);
    if (n >= 50) begin
      test_done();
    end
  endtask : bus
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask : rd
  function automatic logic [6:0] actl(input int i);
    return DGT_CTL_BASE + 7'(4 * i);
  endfunction : actl
  function automatic logic [6:0] acnt(input int i);
    return DGT_CNT_BASE + 7'(4 * i);
  endfunction : acnt
  task automatic rd_chk(input string what, input logic [6:0] a,
      input logic [15:0] exp);
    logic [15:0] q;
    rd(a, q);
    check(what, q, exp);
  endtask : rd_chk
  task automatic drive(input int which, input logic v);
    @(posedge clk);
    case (which)
      0: pin_in <= v;
      1: aux_b_in <= v;
      3: pin_dir <= v;
      default: cap_pin <= v;
    endcase
    repeat (2) @(posedge clk);
  endtask : drive
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      drive(which, 1'b1);
      drive(which, 1'b0);
    end
    repeat (4) @(posedge clk);
  endtask : pulse
  // Two reads exactly 40 clocks apart, a multiple of each tick period tested here (2, 4 and 8 clocks)
  task automatic rate(input int t, input logic [15:0] ctl,
      input logic [15:0] exp);
    logic [15:0] a;
    logic [15:0] b;
    wr(acnt(t), 16'h0000);
    wr(actl(t), ctl);
    rd(acnt(t), a);
    repeat (37) @(posedge clk);
    rd(acnt(t), b);
    wr(actl(t), 16'h0000);
    check("tick delta", b - a, exp);
  endtask : rate
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (core_out !== lvl && n < 500) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (core_out === lvl && n < 500) begin
      @(negedge clk);
      n++;
    end
  endtask : span
  task automatic quad(input logic back, input int steps);
    @(posedge clk);
    quad_rev <= back;
    quad_go <= 1'b1;
    repeat (4 * steps) @(posedge clk);
    quad_go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : quad
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    $display("unexpected watchdog expiry");
    test_done();
  end
  initial begin
    logic [15:0] v;
    int h;
    int l;
    int c;
    {reset_n, avs_read, avs_write, pin_in, pin_dir, aux_b_in} = '0;
    {g2_aux_in, g2_aux_dir, g2_core_in, cap_pin, quad_sel} = '0;
    {quad_go, quad_rev} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < DGT_NUM_TIMERS; i++) begin
      rd_chk("control reset", actl(i), DGT_CTL_RST);
      wr(acnt(i), 16'hFFFF);
      rd_chk("count width", acnt(i), 16'hFFFF);
    end
    wr(7'h4C, 16'h00FF);
    rd_chk("unmapped", 7'h4C, 16'h0000);
    $display("test registers complete");
    rate(DGT_CORE, 16'h0020, 16'h000A);
    rate(DGT_CORE, 16'h0024, 16'h0005);
    rate(DGT_AUX_A, 16'h0060, 16'hFFF6);
    rate(DGT_G2_CORE, 16'h0020, 16'h0014);
    g2_aux_dir <= 1'b1;
    rate(DGT_G2_AUX, 16'h00A0, 16'hFFEC);
    g2_aux_dir <= 1'b0;
    $display("test rates complete");
    wr(DGT_STATUS, 16'h001F);
    wr(acnt(DGT_CORE), 16'hFFFF);
    c = ev_n;
    wr(actl(DGT_CORE), 16'h0020);
    repeat (10) @(negedge clk);
    wr(actl(DGT_CORE), 16'h0000);
    check("core latch", {15'h0000, core_out}, 16'h0001);
    check("wrap pulses", 16'(ev_n - c), 16'h0001);
    rd_chk("status", DGT_STATUS, 16'h0002);
    check("flag pins", {11'h000, wrap_fl}, 16'h0002);
    wr(DGT_STATUS, 16'h0002);
    rd_chk("status clear", DGT_STATUS, 16'h0000);
    wr(acnt(DGT_G2_CORE), 16'h0000);
    c = cmp_n;
    wr(actl(DGT_G2_CORE), 16'h0060);
    repeat (6) @(negedge clk);
    wr(actl(DGT_G2_CORE), 16'h0000);
    check("second latch", {15'h0000, core2_out}, 16'h0001);
    check("array clock", 16'(cmp_n - c), 16'h0001);
    $display("test wraps complete");
    wr(acnt(DGT_CORE), 16'h0000);
    wr(actl(DGT_CORE), 16'h0122);
    pulse(0, 5);
    rd_chk("counted", acnt(DGT_CORE), 16'h0005);
    pin_dir <= 1'b1;
    wr(actl(DGT_CORE), 16'h01A2);
    pulse(0, 2);
    rd_chk("counted down", acnt(DGT_CORE), 16'h0003);
    pin_dir <= 1'b0;
    wr(acnt(DGT_CORE), 16'h0000);
    wr(actl(DGT_CORE), 16'h0421);
    repeat (40) @(posedge clk);
    rd_chk("gate closed", acnt(DGT_CORE), 16'h0000);
    pin_in <= 1'b1;
    repeat (40) @(posedge clk);
    pin_in <= 1'b0;
    repeat (8) @(posedge clk);
    rd(acnt(DGT_CORE), v);
    check("gate open", {15'h0000, v >= 9 && v <= 11}, 16'h0001);
    $display("test pin modes complete");
    wr(acnt(DGT_CORE), 16'h0000);
    quad_sel <= 1'b1;
    wr(actl(DGT_CORE), 16'h0023);
    quad(1'b0, 8);
    rd_chk("position fwd", acnt(DGT_CORE), 16'h0008);
    quad(1'b1, 4);
    rd_chk("position back", acnt(DGT_CORE), 16'h0004);
    wr(actl(DGT_CORE), 16'h0000);
    quad_sel <= 1'b0;
    $display("test incremental complete");
    wr(acnt(DGT_CORE), 16'h1234);
    wr(acnt(DGT_AUX_B), 16'h0000);
    wr(actl(DGT_AUX_B), 16'h1120);
    pulse(1, 1);
    rd_chk("captured", acnt(DGT_AUX_B), 16'h1234);
    repeat (40) @(posedge clk);
    rd_chk("aux held", acnt(DGT_AUX_B), 16'h1234);
    wr(acnt(DGT_AUX_B), 16'h0100);
    wr(actl(DGT_AUX_B), 16'h0900);
    pulse(1, 1);
    rd_chk("reloaded", acnt(DGT_CORE), 16'h0100);
    wr(acnt(DGT_AUX_A), 16'hFFF0);
    wr(actl(DGT_AUX_A), 16'h2800);
    wr(acnt(DGT_AUX_B), 16'hFFF8);
    wr(actl(DGT_AUX_B), 16'h4800);
    wr(acnt(DGT_CORE), 16'hFFF8);
    wr(actl(DGT_CORE), 16'h0020);
    span(1'b1, h);
    span(1'b0, l);
    span(1'b1, h);
    check("pwm high", 16'(h), 16'h0040);
    check("pwm low", 16'(l), 16'h0020);
    for (int i = 0; i < 3; i++) begin
      wr(actl(i), 16'h0000);
    end
    $display("test capture reload complete");
    wr(acnt(DGT_G2_AUX), 16'h0055);
    wr(DGT_CAPCTL, 16'h0029);
    pulse(2, 1);
    rd_chk("pin capture", DGT_CAP_REG, 16'h0055);
    rd_chk("aux cleared", acnt(DGT_G2_AUX), 16'h0000);
    wr(acnt(DGT_G2_AUX), 16'h0077);
    wr(DGT_CAPCTL, 16'h0002);
    pulse(0, 1);
    rd_chk("input capture", DGT_CAP_REG, 16'h0077);
    wr(acnt(DGT_G2_AUX), 16'h0066);
    wr(DGT_CAPCTL, 16'h0004);
    pulse(3, 1);
    rd_chk("dir capture", DGT_CAP_REG, 16'h0066);
    wr(DGT_CAP_REG, 16'hFFFC);
    wr(DGT_CAPCTL, 16'h0010);
    wr(acnt(DGT_G2_CORE), 16'hFFFF);
    wr(actl(DGT_G2_CORE), 16'h0020);
    repeat (20) @(negedge clk);
    c = cmp_n;
    repeat (80) @(negedge clk);
    check("reload period", 16'(cmp_n - c), 16'h000A);
    wr(actl(DGT_G2_CORE), 16'h0000);
    $display("test group two complete");
    test_done();
  end
endmodule : dual_group_timer_unit_bench
`default_nettype wire
